/* File: bench/limit_timer_oneshot_assertions.sv */
// Purpose: port assertions for the limit timer one-shot core
// Assumes: one clock, srst synchronous and active high
// Notes:   mode and enable are mirrored from software writes only
`include "limit_timer_defines.vh"
`default_nettype none
module limit_timer_oneshot_assertions
(
    input wire logic               clk,
    input wire logic               srst,
    input wire logic [`ADDR_W-1:0] regAddr,
    input wire logic [7:0]         regWrData,
    input wire logic               regWr,
    input wire logic               regRd,
    input wire logic               externalResetTrigger,
    input wire logic               debugMode,
    input wire logic [7:0]         regRdData_ff,
    input wire logic [`CNT_W-1:0]  countValue_ff,
    input wire logic               running_ff,
    input wire logic               periodMatch_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] modeMir_ff; // last mode written
    logic       enMir_ff;   // last enable written, blind to hw clears
    logic       onWr;       // software sets enable this cycle
    logic       isRes;      // reserved mode code selected
    assign onWr  = regWr && regAddr == `REG_CTRL && regWrData[7];
    assign isRes = !(modeMir_ff[4:3] == 2'b01 || modeMir_ff inside
        {`MODE_MS_RISE, `MODE_MS_FALL, `MODE_MS_ANY, `MODE_LV_HISTART,
         `MODE_LV_LOSTART});
    // mirror the fields so properties can qualify on the mode
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            modeMir_ff <= 5'h00;
            enMir_ff   <= 1'b0;
        end
        else if (regWr && regAddr == `REG_MODE)
            modeMir_ff <= regWrData[4:0];
        else if (regWr && regAddr == `REG_CTRL)
            enMir_ff <= regWrData[7];
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    chk_match_zero: assert property (
        periodMatch_ff |-> countValue_ff == 8'h00 && !running_ff)
        else $error("counter not parked at zero on match");
    chk_count_step: assert property (
        running_ff && $past(running_ff) && countValue_ff != 8'h00
        |-> countValue_ff == $past(countValue_ff) + 8'h01)
        else $error("counter did not step by one");
    chk_mode_read: assert property (
        $past(regRd && regAddr == `REG_MODE)
        |-> regRdData_ff[4:0] == modeMir_ff)
        else $error("mode readback wrong");
    chk_read_idle: assert property (
        !$past(regRd) |-> regRdData_ff == 8'h00)
        else $error("read data outside its cycle");
    chk_reserved_idle: assert property (
        isRes [*4] |-> !running_ff && countValue_ff == 8'h00)
        else $error("reserved mode not idle");
    chk_sw_start: assert property (
        onWr && modeMir_ff == `MODE_OS_SW && !running_ff
        |-> ##1 !running_ff ##1 !running_ff ##1 !running_ff
        ##1 running_ff)
        else $error("software start latency wrong");
    chk_mono_start: assert property (
        modeMir_ff == `MODE_MS_RISE && enMir_ff && !debugMode
        && !running_ff && $rose(externalResetTrigger) |-> ##3 running_ff)
        else $error("rising edge did not start counter");
    chk_debug_quiet: assert property (
        (debugMode && !running_ff && modeMir_ff == `MODE_MS_RISE) [*4]
        |=> !running_ff)
        else $error("trigger acted in debug mode");
    chk_level_hold: assert property (
        (modeMir_ff == `MODE_LV_LOSTART && enMir_ff
        && externalResetTrigger) [*6] |-> countValue_ff == 8'h00)
        else $error("high level did not hold counter at zero");
endmodule
bind limit_timer_oneshot limit_timer_oneshot_assertions u_chk (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .debugMode(debugMode),
    .externalResetTrigger(externalResetTrigger),
    .regRdData_ff(regRdData_ff), .countValue_ff(countValue_ff),
    .running_ff(running_ff), .periodMatch_ff(periodMatch_ff));
`default_nettype wire

/* File: bench/test_limit_timer_oneshot.sv */
// Purpose: self-checking bench for the limit timer one-shot core
// Assumes: trigger model drives the external signal
// Notes:   period 3 keeps each triggered run short
`include "limit_timer_defines.vh"
`default_nettype none
module test_limit_timer_oneshot;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, regWr, regRd, debugMode, extTrig, running, match;
    logic [2:0] regAddr;
    logic [7:0] regWrData, rdData, count;
    int error_cnt = 0, n_checks = 0, i;
    // modes and expected start on {rising, falling} edge
    logic [4:0] modes [14] = '{5'h11, 5'h12, 5'h13, 5'h16, 5'h17, 5'h14,
                               5'h18, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
                               5'h0e, 5'h0f};
    logic [1:0] starts [14] = '{2'b10, 2'b01, 2'b11, 2'b10, 2'b01, 2'b00,
                                2'b00, 2'b10, 2'b01, 2'b10, 2'b10, 2'b01,
                                2'b10, 2'b01};
    limit_timer_oneshot u_limit_timer_oneshot (.clk(clk), .srst(srst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .externalResetTrigger(extTrig),
        .debugMode(debugMode), .regRdData_ff(rdData),
        .countValue_ff(count), .running_ff(running),
        .periodMatch_ff(match));
    trigger_source u_src (.clk(clk), .extTrig(extTrig));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        cmp(rdData, e);
    endtask
    // a bounded look for one match pulse
    task automatic waitMatch(input logic e);
        logic hit;
        hit = 1'b0;
        repeat (16)
        begin
            @(posedge clk);
            #1;
            if (match === 1'b1) hit = 1'b1;
        end
        cmp({7'h00, hit}, {7'h00, e});
    endtask
    task automatic test_done;
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        srst = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        debugMode = 1'b0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(`REG_MODE, 8'h00);
        rd(`REG_PERIOD, 8'hff);
        rd(3'h5, 8'h00);
        rd(`REG_STATUS, 8'h04);
        wr(`REG_PERIOD, 8'h05);
        wr(`REG_MODE, {3'h0, `MODE_OS_SW});
        wr(`REG_CTRL, 8'h80);
        repeat (2) @(posedge clk);
        #1;
        cmp({7'h00, running}, 8'h00);
        @(posedge clk);
        #1;
        cmp({7'h00, running}, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        cmp(count, 8'h02);
        waitMatch(1'b1);
        rd(`REG_CTRL, 8'h00);
        rd(`REG_COUNT, 8'h00);
        wr(`REG_CTRL, 8'h35);
        rd(`REG_CTRL, 8'h35);
        wr(`REG_PERIOD, 8'h03);
        for (i = 0; i < 14; i++)
        begin
            wr(`REG_CTRL, 8'h00);
            wr(`REG_MODE, {3'h0, modes[i]});
            wr(`REG_CTRL, 8'h80);
            repeat (2) @(posedge clk);
            u_src.drive(1'b1);
            waitMatch(starts[i][1]);
            u_src.drive(1'b0);
            waitMatch(starts[i][0]);
        end
        wr(`REG_CTRL, 8'h00);
        wr(`REG_MODE, {3'h0, `MODE_MS_RISE});
        u_src.drive(1'b1);
        wr(`REG_CTRL, 8'h80);
        waitMatch(1'b0);
        u_src.drive(1'b0);
        u_src.drive(1'b1);
        waitMatch(1'b1);
        @(posedge clk);
        debugMode <= 1'b1;
        u_src.drive(1'b0);
        u_src.drive(1'b1);
        waitMatch(1'b0);
        test_done;
    end
    // cut a hang short well past the expected run length
    initial
    begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        test_done;
    end
endmodule
`default_nettype wire

/* File: bench/trigger_source.sv */
// Purpose: bench model that drives the external trigger signal
// Assumes: called just after a clock edge
// Notes:   each level is held six clocks
`default_nettype none
module trigger_source
(
    input  wire logic clk,     // timer clock
    output var  logic extTrig  // trigger level towards the timer
);
    timeunit 1ns;
    timeprecision 1ps;
    initial extTrig = 1'b0; // idle low from time zero
    // six clocks cover edge spacing and minimum level length alike
    task automatic drive(input logic lvl);
        @(posedge clk);
        extTrig <= lvl;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: hw/limit_timer_defines.vh */
// Purpose: constants for the limit timer one-shot / monostable core
// Assumes: one timer clock at 125 MHz, synchronous active-high reset
// Notes:   mode codes are the five-bit mode field values
`ifndef LIMIT_TIMER_DEFINES_VH
`define LIMIT_TIMER_DEFINES_VH

// mode field layout
`define MODE_W          5
`define MODE_HI_LSB     3
// one-shot group (upper bits 01)
`define MODE_OS_SW      5'h08
`define MODE_OS_RISE    5'h09
`define MODE_OS_FALL    5'h0a
`define MODE_OS_ANY     5'h0b
`define MODE_OS_HLRISE  5'h0c
`define MODE_OS_HLFALL  5'h0d
`define MODE_OS_RISELO  5'h0e
`define MODE_OS_FALLHI  5'h0f
// monostable group (upper bits 10)
`define MODE_MS_RISE    5'h11
`define MODE_MS_FALL    5'h12
`define MODE_MS_ANY     5'h13
// level-triggered one-shot
`define MODE_LV_HISTART 5'h16
`define MODE_LV_LOSTART 5'h17
// widths and reset values
`define CNT_W           8
`define PS_W            4
`define CNT_RST         8'h00
`define PERIOD_RST      8'hff
`define SCALE_ONE       4'h0
// synchroniser depth for enable and trigger (at least two clocks)
`define SYNC_STAGES     2
// register offsets of the plain register port
`define ADDR_W          3
`define REG_CTRL        3'h0
`define REG_MODE        3'h1
`define REG_PERIOD      3'h2
`define REG_COUNT       3'h3
`define REG_STATUS      3'h4
// control register fields
`define CTRL_ON_BIT     7
`define CTRL_PS_LSB     4
`define CTRL_OPS_LSB    0

`endif

/* File: hw/limit_timer_oneshot.v */
// Purpose: one-shot, monostable and level one-shot control of an 8-bit
//          hardware-limit timer with a plain register port
// Assumes: trigger input synchronous to clk, one timer clock per clk
// Notes:   prescale and postscale fields are stored; only 1:1 is timed
`include "limit_timer_defines.vh"
`default_nettype none

// What this block does
// - software one-shot counts once enable is set
// - edge modes need fresh edge after re-enable
// - one-shot match clears enable, counter to zero
// - monostable match stops at zero, enable kept
// - monostable rising, falling, any edge start
// - level code 111: fall starts, high resets
// - enable and trigger pass two-flop synchroniser
// - trigger delay at least one period
// - enable write acts in following period
// - cleared scale fields mean division 1:1
// - no pwm outputs produced here
// - five-bit mode field selects operation
// - debug mode ignores external trigger
module limit_timer_oneshot
(
    input  wire                clk,            // timer clock
    input  wire                srst,           // sync reset, high
    input  wire [`ADDR_W-1:0]  regAddr,        // register address
    input  wire [7:0]          regWrData,      // write data
    input  wire                regWr,          // write strobe
    input  wire                regRd,          // read strobe
    input  wire                externalResetTrigger, // trigger signal
    input  wire                debugMode,      // core halted in debug
    output reg  [7:0]          regRdData_ff,   // read data, cycle after
    output reg  [`CNT_W-1:0]   countValue_ff,  // counter value
    output reg                 running_ff,     // counter advancing
    output reg                 periodMatch_ff  // pulse on period wrap
);

    // software state
    reg                  enable_ff;            // enable bit
    reg [`MODE_W-1:0]    mode_ff;              // mode field
    reg [`CNT_W-1:0]     periodValue_ff;       // period register
    reg [`PS_W-1:0]      prescaleSelect_ff;    // stored only
    reg [`PS_W-1:0]      postscaleSelect_ff;   // stored only

    // synchronisers: first stage read only by the second
    reg [`SYNC_STAGES-1:0] enSync_ff;          // enable pipeline
    reg [`SYNC_STAGES-1:0] trgSync_ff;         // trigger pipeline
    reg                    trgPrev_ff;         // for edge detect
    reg                    armed_ff;           // waiting for an edge
    reg [7:0]              nxt_regRdData;      // read data, next cycle

    // synchronised views; edge pulses compare the synchronised level
    // with the sample one clock older, and debug mode masks them all
    wire enS   = enSync_ff[`SYNC_STAGES-1];
    wire trgS  = trgSync_ff[`SYNC_STAGES-1];
    wire rise  = trgS & ~trgPrev_ff & ~debugMode;
    wire fall  = ~trgS & trgPrev_ff & ~debugMode;
    wire trgHi = trgS & ~debugMode;
    wire trgLo = ~trgS & ~debugMode;

    // mode group decode, used by several processes
    function isOneShot;
        input [`MODE_W-1:0] m;
        begin
            isOneShot = (m[4:3] == 2'b01)
                        || (m == `MODE_LV_HISTART)
                        || (m == `MODE_LV_LOSTART);
        end
    endfunction

    // monostable group: the three edge-start codes
    function isMono;
        input [`MODE_W-1:0] m;
        begin
            isMono = (m == `MODE_MS_RISE) || (m == `MODE_MS_FALL)
                     || (m == `MODE_MS_ANY);
        end
    endfunction

    // start event for the selected mode
    reg startEvt;
    // level reset hold for the selected mode
    reg holdRst;
    always @*
    begin
        startEvt = 1'b0;
        holdRst  = 1'b0;
        case (mode_ff)
            // software start: the enable bit alone starts the count
            `MODE_OS_SW:
                startEvt = 1'b1;
            // rising-edge start, one-shot and monostable alike
            `MODE_OS_RISE, `MODE_OS_HLRISE, `MODE_MS_RISE:
                startEvt = rise;
            // falling-edge start
            `MODE_OS_FALL, `MODE_OS_HLFALL, `MODE_MS_FALL:
                startEvt = fall;
            // either edge starts
            `MODE_OS_ANY, `MODE_MS_ANY:
                startEvt = rise | fall;
            // rising start, low level holds the count at zero
            `MODE_OS_RISELO:
            begin
                startEvt = rise;
                holdRst  = trgLo;
            end
            // falling start, high level holds the count at zero
            `MODE_OS_FALLHI:
            begin
                startEvt = fall;
                holdRst  = trgHi;
            end
            // level one-shot: 110 rise starts, low level resets; 111 fall starts, high level resets
            `MODE_LV_HISTART:
            begin
                startEvt = rise;
                holdRst  = trgLo;
            end
            `MODE_LV_LOSTART:
            begin
                startEvt = fall;
                holdRst  = trgHi;
            end
            // reserved and out-of-group codes never start
            default:
            begin
                startEvt = 1'b0;
                holdRst  = 1'b0;
            end
        endcase
    end

    // hardware-limit one-shots also reset the count on later edges
    wire edgeRst = ((mode_ff == `MODE_OS_HLRISE) && rise)
                   || ((mode_ff == `MODE_OS_HLFALL) && fall);
    // period match only counts while running, so a parked counter at
    // zero never matches a period of zero by accident
    wire match   = running_ff && (countValue_ff == periodValue_ff);
    // codes outside the one-shot and monostable groups are reserved
    wire legal   = isOneShot(mode_ff) || isMono(mode_ff);

    // synchronisers; trigger delay covers at least one period
    // enable rides its own two flops, as deep as the trigger's, so neither races
    always @(posedge clk)
    begin
        if (srst)
        begin
            enSync_ff  <= {`SYNC_STAGES{1'b0}};
            trgSync_ff <= {`SYNC_STAGES{1'b0}};
            // history starts at the idle low level: no false edge
            trgPrev_ff <= 1'b0;
        end
        else
        begin
            enSync_ff  <= {enSync_ff[0], enable_ff};
            trgSync_ff <= {trgSync_ff[0], externalResetTrigger};
            trgPrev_ff <= trgS;
        end
    end

    // counter control; all state steps once per clock
    always @(posedge clk)
    begin
        if (srst)
        begin
            countValue_ff  <= `CNT_RST;
            running_ff     <= 1'b0;
            armed_ff       <= 1'b1;
            periodMatch_ff <= 1'b0;
        end
        else
        begin
            periodMatch_ff <= match;
            if (!enS || !legal)
            begin
                // disabled or reserved: idle, rearm for a fresh edge
                running_ff <= 1'b0;
                armed_ff   <= 1'b1;
                if (!legal)
                    countValue_ff <= `CNT_RST;
            end
            else if (match)
            begin
                // stop at zero; enable handling in the register process
                countValue_ff <= `CNT_RST;
                running_ff    <= 1'b0;
                // only monostable rearms here; a one-shot waits until
                // its cleared enable has passed the synchroniser, or it
                // would restart in the two clocks of lag
                armed_ff      <= !isOneShot(mode_ff);
            end
            else if (holdRst)
            begin
                // level reset: count parked at zero until released
                countValue_ff <= `CNT_RST;
                running_ff    <= 1'b0;
            end
            else if (running_ff)
            begin
                // later edges of hardware-limit one-shots restart it
                if (edgeRst)
                    countValue_ff <= `CNT_RST;
                else
                    countValue_ff <= countValue_ff + 8'h01;
            end
            else if (armed_ff && startEvt)
            begin
                // no fresh edge is needed again until rearmed
                running_ff <= 1'b1;
                armed_ff   <= 1'b0;
            end
        end
    end

    // one-shot completion: hardware drops the enable bit on the match
    wire oneShotDone = enS && legal && match && isOneShot(mode_ff);

    // write decode of the plain register port
    wire wrCtrl   = regWr && (regAddr == `REG_CTRL);    // control
    wire wrMode   = regWr && (regAddr == `REG_MODE);    // mode field
    wire wrPeriod = regWr && (regAddr == `REG_PERIOD);  // period

    // control register; a software write in the match cycle wins over
    // the hardware clear; enable then stays set, but armed_ff stays low, so the one-shot does not restart
    always @(posedge clk)
    begin
        if (srst)
        begin
            enable_ff          <= 1'b0;
            prescaleSelect_ff  <= `SCALE_ONE;
            postscaleSelect_ff <= `SCALE_ONE;
        end
        else if (wrCtrl)
        begin
            // bit 7 is the enable, so prescale owns only the three below
            enable_ff          <= regWrData[`CTRL_ON_BIT];
            prescaleSelect_ff  <= {1'b0,
                                   regWrData[`CTRL_PS_LSB+:`PS_W-1]};
            postscaleSelect_ff <= regWrData[`CTRL_OPS_LSB+:`PS_W];
        end
        else if (oneShotDone)
        begin
            // hardware clear when a one-shot run completes
            enable_ff <= 1'b0;
        end
    end

    // mode and period hold their value until software writes them
    always @(posedge clk)
    begin
        if (srst)
        begin
            mode_ff        <= {`MODE_W{1'b0}};    // reserved code: idle
            periodValue_ff <= `PERIOD_RST;
        end
        else
        begin
            if (wrMode)
                mode_ff <= regWrData[`MODE_W-1:0];
            if (wrPeriod)
                periodValue_ff <= regWrData;
        end
    end

    // read multiplexer; the strobe gates it so the data stand for one
    // cycle only and then fall back to zero
    always @*
    begin
        nxt_regRdData = 8'h00;
        if (!regRd)
            nxt_regRdData = 8'h00;
        else if (regAddr == `REG_CTRL)
            nxt_regRdData = {enable_ff, prescaleSelect_ff[2:0],
                             postscaleSelect_ff};
        else if (regAddr == `REG_MODE)
            nxt_regRdData = {3'h0, mode_ff};
        else if (regAddr == `REG_PERIOD)
            nxt_regRdData = periodValue_ff;
        else if (regAddr == `REG_COUNT)
            nxt_regRdData = countValue_ff;
        // status: armed, synchronised enable, running
        else if (regAddr == `REG_STATUS)
            nxt_regRdData = {5'h00, armed_ff, enS, running_ff};
        else
            nxt_regRdData = 8'h00;    // unmapped reads as zero
    end

    // read data register: the port comes straight from this flop
    always @(posedge clk)
    begin
        if (srst)
            regRdData_ff <= 8'h00;
        else
            regRdData_ff <= nxt_regRdData;
    end

    // pwm drive belongs to the compare unit outside

endmodule

`default_nettype wire
